// [rtl/vam_pkg.sv]
package vam_pkg;
    localparam int          MW          = 16;
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_VACT      = 8'h04;
    localparam logic [7:0]  A_IPICK     = 8'h08;
    localparam logic [7:0]  A_MAXT      = 8'h0c;
    localparam logic [7:0]  A_STAT      = 8'h10;
    localparam logic [7:0]  A_IRQ       = 8'h14;
    localparam logic [7:0]  A_MASK      = 8'h18;
    // Voltage in 0.1 V steps, time in 10 ms steps
    localparam logic [15:0] VACT_MIN    = 16'h0014;
    localparam logic [15:0] VACT_MAX    = 16'h01f4;
    localparam logic [15:0] VACT_RST    = 16'h0064;
    localparam logic [15:0] MAXT_MIN    = 16'h0002;
    localparam logic [15:0] MAXT_MAX    = 16'h1388;
    localparam logic [15:0] MAXT_RST    = 16'h0032;
    localparam logic [15:0] IPICK_RST   = 16'h0100;
    localparam int          CLK_MHZ     = 250;
    localparam int          STEP_MS     = 10;
    localparam int          STEP_CYC    = CLK_MHZ * 1000 * STEP_MS;
    localparam int          PROG_MS     = 5;
    // Control bit positions
    localparam int          C_EN        = 0;
    localparam int          C_ICOND     = 1;
    localparam int          C_FCT       = 2;
    localparam int          C_EVON      = 3;
    localparam int          C_EVOFF     = 4;
    localparam int          C_F60       = 5;
    localparam int          C_MODE      = 6;
    localparam logic [7:0]  CTRL_RST    = 8'h18;
    localparam int          NEV         = 12;
    typedef enum logic [1:0] {
        VAM_3LN  = 2'h0,
        VAM_3LL  = 2'h1,
        VAM_2LL  = 2'h2,
        VAM_2LLR = 2'h3
    } vam_mode_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACT  = 3'b010,
        ST_EXP  = 3'b100
    } vam_st_e;
    typedef struct packed {
        logic [MW-1:0] ia;
        logic [MW-1:0] ib;
        logic [MW-1:0] ic;
        logic [MW-1:0] u1;
        logic [MW-1:0] u2;
        logic [MW-1:0] u3;
        logic [MW-1:0] u4;
    } vam_meas_s;
    typedef struct packed {
        logic [MW-1:0] a;
        logic [MW-1:0] b;
        logic [MW-1:0] c;
    } vam_tri_s;
    // Event bit positions in status and mask
    localparam int E_EN    = 0;
    localparam int E_DIS   = 1;
    localparam int E_VLON  = 2;
    localparam int E_VLOFF = 3;
    localparam int E_IHON  = 4;
    localparam int E_IHOFF = 5;
    localparam int E_FTON  = 6;
    localparam int E_FTOFF = 7;
    localparam int E_MUON  = 8;
    localparam int E_MUOFF = 9;
    localparam int E_BKON  = 10;
    localparam int E_BKOFF = 11;
endpackage

// [rtl/vam_voltage_memory.sv]
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
// Function
// - Voltage low only when every used phase voltage is below activation level.
// - Activation level setting clamped to 2 to 50 V AC.
// - Optional current condition needs one phase current above pickup.
// - Active memory presents activation level as reference amplitude.
// - Angles from before the fault are latched and held while active.
// - Memory-in-use output is high whenever memory is active.
// - Blocking input is sampled at the start of each program cycle.
// - Inputs are RMS currents and four voltages updated every 5 ms.
// - Line-neutral and line-line three phase modes use channels A, B, C.
// - Two line-line mode uses only channels A and B, U12 and U32.
// - Two line-line plus residual mode uses calculated phase-neutral voltages.
// - Maximum active time 0.02 to 50 s ends the memory.
// - After expiry directional stages are switched non-directional.
// - Fixed tracking samples at set nominal 50 or 60 Hz.
// - Forced current tracking with voltages gone uses phase C current.
// - User selects ON events, OFF events, or both for storage.
// - Events for enable, disable and ON/OFF of five conditions.
module vam_voltage_memory
    import vam_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    input  wire logic          prog_cycle_start,
    input  wire vam_meas_s     meas_rms,
    input  wire vam_tri_s      calc_ln_rms,
    input  wire vam_tri_s      voltage_angle,
    input  wire logic          block_in,
    output logic               memory_in_use,
    output logic [MW-1:0]      held_voltage_reference,
    output vam_tri_s           held_angle,
    output logic               non_directional,
    output logic               freq_from_current,
    output logic               nominal_60hz,
    output logic               irq
);

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    logic [7:0]     ctrl_ff;
    logic [15:0]    vact_ff;
    logic [15:0]    ipick_ff;
    logic [15:0]    maxt_ff;
    logic [NEV-1:0] irq_st_ff;
    logic [NEV-1:0] mask_ff;
    logic           wr_ff;
    logic [7:0]     wa_ff;
    logic [31:0]    hrdata_ff;
    logic [NEV-1:0] ev_set;
    vam_st_e        st_ff;
    logic           vlow_ff;
    logic           ihigh_ff;
    logic           block_ff;
    logic           ftrack_ff;
    logic           nondir_ff;
    logic [15:0]    wv;
    logic           acc;
    logic           rd_irq;

    assign acc    = hsel && hready && htrans[1];
    assign rd_irq = acc && !hwrite && (haddr[7:0] == A_IRQ);
    assign wv     = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
        end else begin
            wr_ff <= acc && hwrite;
            wa_ff <= haddr[7:0];
        end
    end

    // Zero wait state: the slave never stalls and always answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff  <= CTRL_RST;
            vact_ff  <= VACT_RST;
            ipick_ff <= IPICK_RST;
            maxt_ff  <= MAXT_RST;
            mask_ff  <= '0;
        end else if (wr_ff) begin
            case (wa_ff)
                A_CTRL:  ctrl_ff  <= hwdata[7:0];
                A_VACT: begin
                    if (wv < VACT_MIN)
                        vact_ff <= VACT_MIN;
                    else if (wv > VACT_MAX)
                        vact_ff <= VACT_MAX;
                    else
                        vact_ff <= wv;
                end
                A_IPICK: ipick_ff <= wv;
                A_MAXT: begin
                    if (wv < MAXT_MIN)
                        maxt_ff <= MAXT_MIN;
                    else if (wv > MAXT_MAX)
                        maxt_ff <= MAXT_MAX;
                    else
                        maxt_ff <= wv;
                end
                A_MASK:  mask_ff  <= hwdata[NEV-1:0];
                default: ;
            endcase
        end
    end

    // Read data is prepared during the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= '0;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                A_CTRL:  hrdata_ff <= {24'h0, ctrl_ff};
                A_VACT:  hrdata_ff <= {16'h0, vact_ff};
                A_IPICK: hrdata_ff <= {16'h0, ipick_ff};
                A_MAXT:  hrdata_ff <= {16'h0, maxt_ff};
                A_STAT:  hrdata_ff <= {24'h0, st_ff, nondir_ff, ftrack_ff, block_ff, ihigh_ff, vlow_ff};
                A_IRQ:   hrdata_ff <= {20'h0, irq_st_ff};
                A_MASK:  hrdata_ff <= {20'h0, mask_ff};
                default: hrdata_ff <= '0;
            endcase
        end
    end
    assign hrdata = hrdata_ff;

    // ---------------------------------------------------------------
    // Program cycle sampling
    // ---------------------------------------------------------------
    logic           en;
    logic [15:0]    ua;
    logic [15:0]    ub;
    logic [15:0]    uc;
    logic           use_c;
    logic           vlow_now;
    logic           ihigh_now;
    vam_tri_s       ang_prev_ff;
    vam_mode_e      mode;

    assign en   = ctrl_ff[C_EN];
    assign mode = vam_mode_e'(ctrl_ff[C_MODE+1:C_MODE]);

    always_comb begin
        ua    = meas_rms.u1;
        ub    = meas_rms.u2;
        uc    = meas_rms.u3;
        use_c = 1'b1;
        case (mode)
            VAM_2LL: begin
                use_c = 1'b0;
            end
            VAM_2LLR: begin
                ua = calc_ln_rms.a;
                ub = calc_ln_rms.b;
                uc = calc_ln_rms.c;
            end
            default: ;
        endcase
    end

    // U4 carries the residual channel and never takes part in the test
    assign vlow_now  = (ua < vact_ff) && (ub < vact_ff) && (!use_c || (uc < vact_ff));
    assign ihigh_now = (meas_rms.ia > ipick_ff) || (meas_rms.ib > ipick_ff) ||
                       (meas_rms.ic > ipick_ff);

    // Voltage, current and block conditions refresh only on the 5 ms strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vlow_ff  <= 1'b0;
            ihigh_ff <= 1'b0;
            block_ff <= 1'b0;
        end else if (prog_cycle_start) begin
            vlow_ff  <= en && vlow_now;
            ihigh_ff <= en && ihigh_now;
            block_ff <= en && block_in;
        end
    end

    // Capture stops on the strobe that sees the collapse, so the
    // fault cycle's own angles never reach the reference
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ang_prev_ff <= '0;
        end else if (prog_cycle_start && !vlow_now) begin
            ang_prev_ff <= voltage_angle;
        end
    end

    // ---------------------------------------------------------------
    // Active time
    // ---------------------------------------------------------------
    logic [31:0]    div_ff;
    logic           step;
    logic [15:0]    tcnt_ff;

    assign step = (div_ff == 32'(STEP_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= '0;
        end else if (st_ff != ST_ACT || step) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcnt_ff <= '0;
        end else if (st_ff != ST_ACT) begin
            tcnt_ff <= '0;
        end else if (step) begin
            tcnt_ff <= tcnt_ff + 16'h1;
        end
    end

    // ---------------------------------------------------------------
    // Memory state
    // ---------------------------------------------------------------
    logic           crit;
    logic           eval_ff;
    vam_st_e        nxt_st;

    assign crit = vlow_ff && (!ctrl_ff[C_ICOND] || ihigh_ff);

    // Activation judged only on fresh samples, never on a settings write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            eval_ff <= 1'b0;
        else
            eval_ff <= prog_cycle_start;
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (eval_ff && crit && !block_ff)
                    nxt_st = ST_ACT;
            end
            ST_ACT: begin
                if (block_ff || !vlow_ff)
                    nxt_st = ST_IDLE;
                else if (tcnt_ff >= maxt_ff)
                    nxt_st = ST_EXP;
            end
            ST_EXP: begin
                // Held until voltage returns, so a new fault re-arms cleanly
                if (!vlow_ff)
                    nxt_st = ST_IDLE;
            end
            default: nxt_st = ST_IDLE;
        endcase
        if (!en)
            nxt_st = ST_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            st_ff <= ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            memory_in_use          <= 1'b0;
            held_voltage_reference <= '0;
            held_angle             <= '0;
            nondir_ff              <= 1'b0;
        end else begin
            memory_in_use <= (nxt_st == ST_ACT);
            nondir_ff     <= (nxt_st == ST_EXP);
            if (st_ff != ST_ACT && nxt_st == ST_ACT) begin
                // Latched so a settings write in mid-fault cannot move it
                held_voltage_reference <= vact_ff;
            end else if (nxt_st != ST_ACT) begin
                held_voltage_reference <= '0;
            end
            if (st_ff == ST_IDLE && nxt_st == ST_ACT)
                held_angle <= ang_prev_ff;
        end
    end
    assign non_directional = nondir_ff;

    // ---------------------------------------------------------------
    // Frequency tracking
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ftrack_ff    <= 1'b0;
            nominal_60hz <= 1'b0;
        end else begin
            ftrack_ff    <= ctrl_ff[C_FCT] && vlow_ff;
            nominal_60hz <= ctrl_ff[C_F60];
        end
    end
    assign freq_from_current = ftrack_ff;

    // ---------------------------------------------------------------
    // Events and interrupt
    // ---------------------------------------------------------------
    logic [4:0]     lvl;
    logic [4:0]     lvl_ff;
    logic           en_ff;
    logic           on_ok;
    logic           off_ok;

    assign lvl    = {block_ff, memory_in_use, ftrack_ff, ihigh_ff, vlow_ff};
    assign on_ok  = ctrl_ff[C_EVON];
    assign off_ok = ctrl_ff[C_EVOFF];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_ff <= '0;
            en_ff  <= 1'b0;
        end else begin
            lvl_ff <= lvl;
            en_ff  <= en;
        end
    end

    always_comb begin
        ev_set        = '0;
        ev_set[E_EN]  = en && !en_ff;
        ev_set[E_DIS] = !en && en_ff;
        for (int i = 0; i < 5; i++) begin
            ev_set[E_VLON + 2*i]  = on_ok && lvl[i] && !lvl_ff[i];
            ev_set[E_VLOFF + 2*i] = off_ok && !lvl[i] && lvl_ff[i];
        end
    end

    // Set wins over the read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_st_ff <= '0;
        else if (rd_irq)
            irq_st_ff <= ev_set;
        else
            irq_st_ff <= irq_st_ff | ev_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |((rd_irq ? ev_set : (irq_st_ff | ev_set)) & mask_ff);
    end

endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import vam_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pcs = 0, blk = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic        hready, hreadyout, hresp, in_use, nondir, ffc, f60, irq, dir_on;
    logic [MW-1:0] vref;
    vam_meas_s m = '0, x, hm;
    vam_tri_s  cl = '0, ang = '0, hang, rang, aa, a2, c, hc;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    logic e;
    logic [7:0]  ca[6] = '{A_VACT, A_VACT, A_VACT, A_MAXT, A_MAXT, A_MAXT};
    logic [15:0] cw[6] = '{16'h0001, 16'hffff, 16'h0064, 16'h0000, 16'hffff, 16'h0032};
    logic [15:0] ce[6] = '{16'h0014, 16'h01f4, 16'h0064, 16'h0002, 16'h1388, 16'h0032};
    assign hready = hreadyout;
    vam_voltage_memory #(.STEP_CYCLES(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .prog_cycle_start(pcs),
        .meas_rms(m), .calc_ln_rms(cl), .voltage_angle(ang), .block_in(blk), .memory_in_use(in_use),
        .held_voltage_reference(vref), .held_angle(hang), .non_directional(nondir),
        .freq_from_current(ffc), .nominal_60hz(f60), .irq);
    vam_dir_stage u_dir (.memory_in_use(in_use), .non_directional(nondir), .held_angle(hang),
        .voltage_angle(ang), .ref_angle(rang), .dir_on);
    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            results();
        end
    end
    task results;
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Block is inverted between strobes to show it only counts on the strobe
    task strobe(input vam_meas_s mm, input vam_tri_s cc, input vam_tri_s an, input logic b);
        @(posedge hclk);
        m <= mm;
        cl <= cc;
        ang <= an;
        blk <= b;
        pcs <= 1;
        @(posedge hclk);
        pcs <= 0;
        blk <= !b;
        repeat (4) @(posedge hclk);
    endtask
    function automatic vam_meas_s mk(logic [15:0] v, logic [15:0] i);
        return {32'h0, i, v, v, v, 16'h0};
    endfunction
    function automatic logic elow(logic [1:0] md, vam_meas_s y, vam_tri_s z, logic [15:0] v);
        if (md == 2'h3)
            return z.a < v && z.b < v && z.c < v;
        if (md == 2'h2)
            return y.u1 < v && y.u2 < v;
        return y.u1 < v && y.u2 < v && y.u3 < v;
    endfunction
    function automatic vam_tri_s rt(int lo, int hi);
        return {16'($urandom_range(hi, lo)), 16'($urandom_range(hi, lo)), 16'($urandom_range(hi, lo))};
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rd = $urandom(32'hdbee);
        hm = mk(16'h0200, 16'h0);
        hc = {3{16'h0200}};
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        bus(0, A_CTRL, 0);
        chk(rd, CTRL_RST);
        bus(1, 8'h1c, 32'hffff);
        bus(0, 8'h1c, 0);
        chk(rd, 0);
        for (int i = 0; i < 6; i++) begin
            bus(1, ca[i], cw[i]);
            bus(0, ca[i], 0);
            chk(rd, ce[i]);
        end
        bus(1, A_MASK, 32'hfff);
        for (int k = 0; k < 32; k++) begin
            bus(1, A_CTRL, {k[1:0], 6'h19});
            aa = rt(0, 16'hffff);
            strobe(hm, hc, aa, 0);
            x = mk(16'h0, 16'h0);
            {x.u1, x.u2, x.u3} = rt(16'h60, 16'h66);
            c = rt(16'h60, 16'h66);
            a2 = rt(0, 16'hffff);
            strobe(x, c, a2, 0);
            e = elow(k[1:0], x, c, VACT_RST);
            chk(in_use, e);
            chk(vref, e ? VACT_RST : 16'h0);
            chk(rang, e ? aa : a2);
        end
        bus(1, A_CTRL, 8'h1b);
        for (int k = 0; k < 2; k++) begin
            strobe(hm, hc, aa, 0);
            strobe(mk(16'h0, 16'h0100 + 16'(k)), hc, aa, 0);
            chk(in_use, k);
        end
        bus(1, A_CTRL, 8'h19);
        for (int k = 0; k < 2; k++) begin
            strobe(hm, hc, aa, 0);
            strobe(mk(16'h0, 16'h0), hc, aa, k);
            chk(in_use, !k);
        end
        bus(1, A_CTRL, 8'h3d);
        strobe(mk(16'h0, 16'h0), hc, aa, 0);
        chk(ffc, 1);
        chk(f60, 1);
        strobe(hm, hc, aa, 0);
        chk(ffc, 0);
        for (int k = 0; k < 2; k++) begin
            bus(1, A_CTRL, k ? 8'h11 : 8'h09);
            bus(0, A_IRQ, 0);
            strobe(mk(16'h0, 16'h0), hc, aa, 0);
            strobe(hm, hc, aa, 0);
            chk(irq, 1);
            bus(0, A_IRQ, 0);
            chk(rd, k ? 32'h208 : 32'h104);
            chk(f60, 0);
        end
        // Events land while masked, so the unmask alone must raise irq
        bus(1, A_MASK, 0);
        strobe(mk(16'h0, 16'h0), hc, aa, 0);
        strobe(hm, hc, aa, 0);
        chk(irq, 0);
        bus(1, A_MASK, 32'hfff);
        repeat (2) @(posedge hclk);
        chk(irq, 1);
        bus(1, A_CTRL, 8'h18);
        bus(1, A_CTRL, 8'h19);
        bus(0, A_IRQ, 0);
        chk(rd[1:0], 2'h3);
        bus(0, A_IRQ, 0);
        chk(irq, 0);
        bus(1, A_MAXT, 32'h2);
        strobe(mk(16'h0, 16'h0), hc, aa, 0);
        chk(in_use, 1);
        repeat (20) @(posedge hclk);
        chk(in_use, 0);
        chk(nondir, 1);
        chk(dir_on, 0);
        strobe(hm, hc, aa, 0);
        chk(nondir, 0);
        results();
    end
endmodule
bind vam_voltage_memory vam_monitor u_mon (.hclk, .hresetn, .hreadyout, .hresp, .prog_cycle_start,
    .block_in, .memory_in_use, .held_voltage_reference, .held_angle, .non_directional, .irq);

// [tb/vam_dir_stage.sv]
`timescale 1ns/1ns
module vam_dir_stage
    import vam_pkg::*;
(
    input wire logic     memory_in_use,
    input wire logic     non_directional,
    input wire vam_tri_s held_angle,
    input wire vam_tri_s voltage_angle,
    output vam_tri_s     ref_angle,
    output logic         dir_on
);
    // Live angle is meaningless once voltage collapses
    assign ref_angle = memory_in_use ? held_angle : voltage_angle;
    assign dir_on    = !non_directional;
endmodule

// [tb/vam_monitor.sv]
`timescale 1ns/1ns
module vam_monitor
    import vam_pkg::*;
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          prog_cycle_start,
    input wire logic          block_in,
    input wire logic          memory_in_use,
    input wire logic [MW-1:0] held_voltage_reference,
    input wire vam_tri_s      held_angle,
    input wire logic          non_directional,
    input wire logic          irq
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ok;
        hreadyout && !hresp;
    endproperty
    a_ok: assert property (p_ok) else $error("bus answer not ready/okay");
    // Second cycle of activity avoids a race with the reference register load
    property p_ref_rng;
        memory_in_use && $past(memory_in_use) |->
            held_voltage_reference >= VACT_MIN && held_voltage_reference <= VACT_MAX;
    endproperty
    a_ref_rng: assert property (p_ref_rng) else $error("reference out of range");
    property p_ref_hold;
        memory_in_use && $past(memory_in_use) |-> $stable(held_voltage_reference);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference moved");
    property p_ang_hold;
        memory_in_use && $past(memory_in_use) |-> $stable(held_angle);
    endproperty
    a_ang_hold: assert property (p_ang_hold) else $error("held angle moved");
    property p_block;
        prog_cycle_start && block_in |-> ##4 !memory_in_use;
    endproperty
    a_block: assert property (p_block) else $error("active while blocked");
    property p_rise;
        $rose(memory_in_use) |-> ($past(prog_cycle_start, 2) && !$past(block_in, 2))
                              || ($past(prog_cycle_start, 3) && !$past(block_in, 3));
    endproperty
    a_rise: assert property (p_rise) else $error("activation off strobe");
    property p_nd_cause;
        $rose(non_directional) |-> $past(memory_in_use) || $past(memory_in_use, 2);
    endproperty
    a_nd_cause: assert property (p_nd_cause) else $error("nondir without memory");
    property p_nd_drop;
        $fell(non_directional) |-> $past(prog_cycle_start, 2) || $past(prog_cycle_start, 3);
    endproperty
    a_nd_drop: assert property (p_nd_drop) else $error("nondir dropped off strobe");
    property p_excl;
        !(memory_in_use && non_directional);
    endproperty
    a_excl: assert property (p_excl) else $error("in use after expiry");
    c_use: cover property ($rose(memory_in_use));
    c_nd: cover property ($rose(non_directional));
    c_irq: cover property ($rose(irq));
endmodule
